/* File: verilog/fcp_defs.vh */
`ifndef FCP_DEFS_VH
`define FCP_DEFS_VH

// Clock and oscillator rates in hertz.
`define FCP_CLK_HZ 20000000
`define FCP_OSC_FAST_HZ 10000000
`define FCP_OSC_SLOW_HZ 1250000
// Half-period of the divided oscillator, in system clock cycles.
`define FCP_HALF_FAST ((`FCP_CLK_HZ) / (2 * (`FCP_OSC_FAST_HZ)))
`define FCP_HALF_SLOW ((`FCP_CLK_HZ) / (2 * (`FCP_OSC_SLOW_HZ)))

// Default mode-pin encodings.
`define FCP_MODE_MSER 3'h0
`define FCP_MODE_SSER 3'h1
`define FCP_MODE_MPAR 3'h2
`define FCP_MODE_SPAR 3'h3
`define FCP_MODE_APER 3'h4
`define FCP_MODE_SPER 3'h5

// Default sizes of the load and of the memory clearing phase.
`define FCP_CFG_BYTES 16
`define FCP_CLEAR_CYCLES 64

// Sequencer state codes.
`define FCP_ST_CLEAR 3'h0
`define FCP_ST_WAIT 3'h1
`define FCP_ST_LOAD 3'h2
`define FCP_ST_START 3'h3
`define FCP_ST_USER 3'h4
`define FCP_ST_RDBK 3'h5

// Number of pin inputs passed through the synchroniser.
`define FCP_SYNC_W 22

`endif

/* File: verilog/fcp_sync.v */
`timescale 1ns/1ps
module fcp_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  input wire clk,
  input wire reset_n,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_r;

  // Two flops; only the second stage is visible outside.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* File: verilog/fcp_top.v */
`timescale 1ns/1ps
`include "fcp_defs.vh"
module fcp_top #(
  parameter [2:0] MODE_MSER = `FCP_MODE_MSER,
  parameter [2:0] MODE_SSER = `FCP_MODE_SSER,
  parameter [2:0] MODE_MPAR = `FCP_MODE_MPAR,
  parameter [2:0] MODE_SPAR = `FCP_MODE_SPAR,
  parameter [2:0] MODE_APER = `FCP_MODE_APER,
  parameter [2:0] MODE_SPER = `FCP_MODE_SPER,
  parameter CFG_BYTES = `FCP_CFG_BYTES,
  parameter CLEAR_CYCLES = `FCP_CLEAR_CYCLES
) (
  input wire clk,
  input wire reset_n,
  input wire config_clock_in,
  output reg config_clock_out,
  output reg config_clock_oe_n,
  input wire serial_data_in,
  input wire [7:0] data_bus_in,
  output reg [7:0] data_bus_out,
  output reg [7:0] data_bus_oe_n,
  input wire mode_select_bit0,
  input wire mode_select_bit1,
  input wire mode_select_bit2,
  input wire osc_speed_select,
  input wire chip_select_low,
  input wire chip_select_high,
  input wire write_strobe_n,
  input wire read_strobe_n,
  input wire program_restart_n,
  input wire gen_reset_n,
  input wire done_in,
  output reg done_out,
  output reg done_oe_n,
  input wire init_in,
  output reg init_out,
  output reg init_oe_n,
  input wire readback_request_n,
  input wire readback_enable,
  input wire tristate_after_cfg,
  input wire gen_reset_is_async,
  input wire scan_select,
  input wire scan_tdo,
  input wire [7:0] readback_byte,
  output reg [7:0] readback_addr,
  output reg readback_data,
  output reg ready_busy,
  output reg mem_read_strobe,
  output reg daisy_data_out,
  output reg high_while_configuring,
  output reg low_while_configuring,
  output reg global_tristate,
  output reg scan_reset,
  output reg config_pullup_en,
  output reg user_io_en,
  output reg user_reset_level,
  output reg user_async_reset,
  output reg [7:0] cfg_byte,
  output reg cfg_byte_valid
);
  wire [`FCP_SYNC_W-1:0] sync_q;
  wire config_clock_s;
  wire din_s;
  wire [7:1] dbus_s;
  wire [2:0] mode_s;
  wire speed_s;
  wire csl_s;
  wire csh_s;
  wire wr_n_s;
  wire rd_n_s;
  wire prog_n_s;
  wire grst_n_s;
  wire done_s;
  wire init_s;
  wire rbreq_n_s;

  // Pin inputs pass two flops before use, except the readback enable, option, scan and readback byte inputs.
  fcp_sync #(.WIDTH(`FCP_SYNC_W), .INIT({`FCP_SYNC_W{1'b1}})) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({config_clock_in, serial_data_in, data_bus_in[7:1],
        mode_select_bit2, mode_select_bit1, mode_select_bit0, osc_speed_select,
        chip_select_low, chip_select_high, write_strobe_n, read_strobe_n,
        program_restart_n, gen_reset_n, done_in, init_in, readback_request_n}),
    .q(sync_q)
  );
  assign {config_clock_s, din_s, dbus_s, mode_s, speed_s, csl_s, csh_s, wr_n_s, rd_n_s,
          prog_n_s, grst_n_s, done_s, init_s, rbreq_n_s} = sync_q;

  reg [2:0] state_r;
  reg [2:0] mode_r;
  reg speed_r;
  reg [6:0] clear_cnt_r;
  reg [3:0] osc_cnt_r;
  reg osc_clk_r;
  reg config_clock_prev_r;
  reg wr_prev_r;
  reg rbreq_prev_r;
  reg [7:0] shift_r;
  reg [2:0] bit_cnt_r;
  reg [7:0] byte_cnt_r;
  reg [7:0] pbuf_r;
  reg pbuf_full_r;
  reg serial_bit_r;
  // Terminal counts, kept as integers and cut to the counter widths below.
  localparam integer HALF_FAST_M1 = `FCP_HALF_FAST - 1;
  localparam integer HALF_SLOW_M1 = `FCP_HALF_SLOW - 1;
  localparam integer CLEAR_LAST = CLEAR_CYCLES - 1;
  localparam integer BYTE_LAST = CFG_BYTES - 1;

  wire master_mode = (mode_r == MODE_MSER) || (mode_r == MODE_MPAR);
  wire drive_clk = master_mode || (mode_r == MODE_APER);
  wire serial_mode = (mode_r == MODE_MSER) || (mode_r == MODE_SSER);
  wire periph_mode = (mode_r == MODE_APER) || (mode_r == MODE_SPER);
  wire selected = !csl_s && csh_s;
  wire [3:0] half_cnt = speed_r ? HALF_SLOW_M1[3:0] : HALF_FAST_M1[3:0];
  wire osc_toggle = (osc_cnt_r == half_cnt);
  wire int_rise = osc_toggle && !osc_clk_r;
  wire int_fall = osc_toggle && osc_clk_r;
  wire ext_rise = config_clock_s && !config_clock_prev_r;
  wire ext_fall = !config_clock_s && config_clock_prev_r;
  wire config_clock_rise = drive_clk ? int_rise : ext_rise;
  wire config_clock_fall = drive_clk ? int_fall : ext_fall;
  wire configuring = (state_r == `FCP_ST_WAIT) || (state_r == `FCP_ST_LOAD) ||
                     (state_r == `FCP_ST_START);
  wire restart = !prog_n_s || (configuring && !grst_n_s);
  wire in_user = (state_r == `FCP_ST_USER) || (state_r == `FCP_ST_RDBK);
  wire wr_fall = selected && !wr_n_s && wr_prev_r;
  wire last_byte = (byte_cnt_r == BYTE_LAST[7:0]);

  // Capture of one configuration byte, per mode, on the clock rise.
  reg take_byte;
  reg [7:0] take_data;
  always @* begin
    take_byte = 1'b0;
    take_data = {dbus_s, din_s};
    if (state_r == `FCP_ST_LOAD && config_clock_rise) begin
      if (serial_mode) begin
        take_byte = (bit_cnt_r == 3'h7);
        take_data = {shift_r[6:0], din_s};
      end else if (mode_r == MODE_APER) begin
        take_byte = pbuf_full_r;
        take_data = pbuf_r;
      end else if (mode_r == MODE_SPAR || mode_r == MODE_SPER) begin
        take_byte = selected && !wr_n_s;
      end else begin
        take_byte = 1'b1;
      end
    end
  end

  // Divided oscillator, running only in the load state.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_cnt_r <= 4'h0;
      osc_clk_r <= 1'b0;
    end else if (state_r != `FCP_ST_LOAD) begin
      osc_cnt_r <= 4'h0;
      osc_clk_r <= 1'b0;
    end else if (osc_toggle) begin
      osc_cnt_r <= 4'h0;
      osc_clk_r <= ~osc_clk_r;
    end else begin
      osc_cnt_r <= osc_cnt_r + 4'h1;
    end
  end

  // Sequencer from memory clearing through loading, start-up and readback.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= `FCP_ST_CLEAR;
      mode_r <= 3'h0;
      speed_r <= 1'b0;
      clear_cnt_r <= 7'h00;
      byte_cnt_r <= 8'h00;
    end else if (restart) begin
      state_r <= `FCP_ST_CLEAR;
      clear_cnt_r <= 7'h00;
      byte_cnt_r <= 8'h00;
    end else begin
      case (state_r)
        `FCP_ST_CLEAR: begin
          clear_cnt_r <= clear_cnt_r + 7'h01;
          if (clear_cnt_r == CLEAR_LAST[6:0]) begin
            state_r <= `FCP_ST_WAIT;
          end
        end
        `FCP_ST_WAIT: begin
          if (init_s) begin
            state_r <= `FCP_ST_LOAD;
            mode_r <= mode_s;
            speed_r <= speed_s;
            byte_cnt_r <= 8'h00;
          end
        end
        `FCP_ST_LOAD: begin
          if (take_byte) begin
            byte_cnt_r <= byte_cnt_r + 8'h01;
            if (last_byte) begin
              state_r <= `FCP_ST_START;
            end
          end
        end
        `FCP_ST_START: begin
          if (done_s) begin
            state_r <= `FCP_ST_USER;
          end
        end
        `FCP_ST_USER: begin
          if (readback_enable && !rbreq_n_s && rbreq_prev_r) begin
            state_r <= `FCP_ST_RDBK;
            byte_cnt_r <= 8'h00;
          end
        end
        `FCP_ST_RDBK: begin
          if (osc_cnt_r == 4'h0 && bit_cnt_r == 3'h7) begin
            byte_cnt_r <= byte_cnt_r + 8'h01;
            if (last_byte) begin
              state_r <= `FCP_ST_USER;
            end
          end
        end
        default: begin
          state_r <= `FCP_ST_CLEAR;
        end
      endcase
    end
  end

  // Serial shifting, peripheral buffer and edge history.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_clock_prev_r <= 1'b1;
      wr_prev_r <= 1'b1;
      rbreq_prev_r <= 1'b1;
      shift_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      pbuf_r <= 8'h00;
      pbuf_full_r <= 1'b0;
      serial_bit_r <= 1'b1;
      cfg_byte <= 8'h00;
      cfg_byte_valid <= 1'b0;
    end else begin
      config_clock_prev_r <= config_clock_s;
      wr_prev_r <= wr_n_s;
      rbreq_prev_r <= rbreq_n_s;
      cfg_byte_valid <= take_byte;
      if (take_byte) begin
        cfg_byte <= take_data;
      end
      if (state_r == `FCP_ST_LOAD && serial_mode && config_clock_rise) begin
        shift_r <= {shift_r[6:0], din_s};
        serial_bit_r <= din_s;
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end else if (state_r == `FCP_ST_RDBK) begin
        if (osc_cnt_r == 4'h0) begin
          bit_cnt_r <= bit_cnt_r + 3'h1;
        end
      end else if (state_r != `FCP_ST_LOAD) begin
        bit_cnt_r <= 3'h0;
      end
      // A new write is kept even if the buffer drains in the same cycle.
      if (state_r == `FCP_ST_LOAD && mode_r == MODE_APER && wr_fall) begin
        pbuf_r <= {dbus_s, din_s};
        pbuf_full_r <= 1'b1;
      end else if (take_byte || state_r != `FCP_ST_LOAD) begin
        pbuf_full_r <= 1'b0;
      end
    end
  end

  // Configuration clock pin, memory read strobe and daisy-chain output.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_clock_out <= 1'b0;
      config_clock_oe_n <= 1'b1;
      mem_read_strobe <= 1'b0;
      daisy_data_out <= 1'b1;
    end else begin
      config_clock_out <= osc_clk_r;
      config_clock_oe_n <= !(state_r == `FCP_ST_LOAD && drive_clk);
      if (state_r == `FCP_ST_LOAD && mode_r == MODE_MPAR) begin
        mem_read_strobe <= !osc_clk_r;
      end else begin
        mem_read_strobe <= 1'b0;
      end
      if (configuring && config_clock_fall) begin
        daisy_data_out <= serial_bit_r;
      end
    end
  end

  // Status, init, done and data-bus status outputs.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_out <= 1'b0;
      done_oe_n <= 1'b0;
      init_out <= 1'b0;
      init_oe_n <= 1'b0;
      ready_busy <= 1'b0;
      data_bus_out <= 8'h00;
      data_bus_oe_n <= 8'hff;
      high_while_configuring <= 1'b1;
      low_while_configuring <= 1'b0;
    end else begin
      done_out <= 1'b0;
      done_oe_n <= !(state_r == `FCP_ST_CLEAR || state_r == `FCP_ST_WAIT ||
                     state_r == `FCP_ST_LOAD);
      init_out <= 1'b0;
      init_oe_n <= !(state_r == `FCP_ST_CLEAR);
      high_while_configuring <= !in_user;
      low_while_configuring <= in_user;
      if (state_r == `FCP_ST_LOAD && periph_mode) begin
        ready_busy <= !pbuf_full_r && !(wr_fall && mode_r == MODE_APER);
      end else begin
        ready_busy <= 1'b0;
      end
      data_bus_out <= {!pbuf_full_r, 7'h00};
      if (state_r == `FCP_ST_LOAD && mode_r == MODE_APER && selected &&
          !rd_n_s && wr_n_s) begin
        data_bus_oe_n <= 8'h7f;
      end else begin
        data_bus_oe_n <= 8'hff;
      end
    end
  end

  // Pin hand-over, tristate, scan reset and general reset routing.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      global_tristate <= 1'b0;
      scan_reset <= 1'b1;
      config_pullup_en <= 1'b1;
      user_io_en <= 1'b0;
      user_reset_level <= 1'b1;
      user_async_reset <= 1'b0;
    end else begin
      global_tristate <= !rbreq_n_s && (!in_user || tristate_after_cfg);
      scan_reset <= !prog_n_s;
      config_pullup_en <= !in_user;
      user_io_en <= in_user;
      user_reset_level <= in_user ? grst_n_s : 1'b1;
      user_async_reset <= in_user && gen_reset_is_async && !grst_n_s;
    end
  end

  // Readback address and shared readback/scan output pin.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readback_addr <= 8'h00;
      readback_data <= 1'b0;
    end else begin
      readback_addr <= (state_r == `FCP_ST_RDBK) ? byte_cnt_r : 8'h00;
      if (scan_select) begin
        readback_data <= scan_tdo;
      end else if (state_r == `FCP_ST_RDBK) begin
        readback_data <= readback_byte[3'h7 - bit_cnt_r];
      end else begin
        readback_data <= 1'b0;
      end
    end
  end
endmodule

/* File: dv/fcp_props.sv */
`timescale 1ns/1ps
// Pin-level relations of the configuration controller, seen from its ports.
module fcp_props (
  input wire clk,
  input wire reset_n,
  input wire done_in,
  input wire program_restart_n,
  input wire readback_request_n,
  input wire config_clock_oe_n,
  input wire [7:0] data_bus_out,
  input wire [7:0] data_bus_oe_n,
  input wire done_oe_n,
  input wire init_oe_n,
  input wire ready_busy,
  input wire mem_read_strobe,
  input wire high_while_configuring,
  input wire low_while_configuring,
  input wire global_tristate,
  input wire scan_reset,
  input wire config_pullup_en,
  input wire user_io_en,
  input wire user_async_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Status outputs and pin handover move together.
  status_pair_a: assert property (high_while_configuring != low_while_configuring)
    else $error("status outputs agree");
  pullup_user_a: assert property (config_pullup_en == high_while_configuring
    && config_pullup_en == !user_io_en) else $error("pull-up and user I/O disagree");
  done_open_a: assert property (user_io_en |-> done_oe_n)
    else $error("done pulled low after start-up");
  startup_hold_a: assert property ((!user_io_en && !done_in) [*4] |=> !user_io_en)
    else $error("start-up while done held low");
  program_restart_a: assert property ((!program_restart_n) [*5] |->
    scan_reset && !init_oe_n && high_while_configuring) else $error("program low ignored");
  init_clear_a: assert property ($rose(reset_n) |-> (!init_oe_n) [*4])
    else $error("init not low while clearing");
  tristate_cfg_a: assert property ((high_while_configuring && !readback_request_n) [*5]
    |-> global_tristate) else $error("no tristate during configuration");
  clock_drive_a: assert property (!config_clock_oe_n |->
    high_while_configuring && !done_oe_n) else $error("clock driven outside loading");
  status_bit_a: assert property (data_bus_oe_n == 8'h7f |-> data_bus_out[7] == ready_busy)
    else $error("status bit differs from ready");
  ready_cfg_a: assert property (ready_busy |-> high_while_configuring && !done_oe_n)
    else $error("ready outside loading");
  read_strobe_a: assert property (mem_read_strobe |-> !config_clock_oe_n)
    else $error("read strobe without clock drive");
  user_async_a: assert property (user_async_reset |-> user_io_en)
    else $error("async reset before start-up");
  cover property ($rose(user_io_en));
  cover property (data_bus_oe_n == 8'h7f);
  cover property ($fell(readback_request_n) && user_io_en);
endmodule

bind fcp_top fcp_props u_props (.clk(clk), .reset_n(reset_n), .done_in(done_in),
  .program_restart_n(program_restart_n), .readback_request_n(readback_request_n),
  .config_clock_oe_n(config_clock_oe_n), .data_bus_out(data_bus_out),
  .data_bus_oe_n(data_bus_oe_n), .done_oe_n(done_oe_n), .init_oe_n(init_oe_n),
  .ready_busy(ready_busy), .mem_read_strobe(mem_read_strobe),
  .high_while_configuring(high_while_configuring),
  .low_while_configuring(low_while_configuring), .global_tristate(global_tristate),
  .scan_reset(scan_reset), .config_pullup_en(config_pullup_en), .user_io_en(user_io_en),
  .user_async_reset(user_async_reset));

/* File: dv/fcp_prom_model.sv */
`timescale 1ns/1ps
// Serial configuration memory: shifts its image out MSB first on the config clock.
module fcp_prom_model #(
  parameter [15:0] IMAGE = 16'h3cc5
) (
  input wire config_clock,
  input wire en,
  output wire din
);
  integer idx = 0;
  // Next bit appears on the falling edge so it is stable across the rise.
  always @(negedge config_clock or negedge en) begin
    if (!en) idx = 0;
    else idx = idx + 1;
  end
  // The line floats to its pull-up when the memory is not being read.
  assign din = (en && idx < 16) ? IMAGE[15 - idx] : 1'b1;
endmodule

/* File: dv/fcp_top_tb.sv */
`timescale 1ns/1ps
module fcp_top_tb;
  logic clk = 0, reset_n = 0, ext_clk = 0, ext_run = 0, use_prom = 1, hold = 1;
  logic osc = 1, csl = 1, csh = 0, wr = 1, rd = 1, prog = 1, grst = 1, rbr = 1, rben = 0;
  logic gra = 0, ssel = 0, stdo = 0;
  logic [2:0] md = 3'h0;
  logic [7:0] bus = 8'h00;
  logic [7:0] rbits = 8'h00;
  wire cco, cco_n, prom_din, dvo, doe, iev, ioe, rbd, rdy, drs, dout, hwc, lwc, gts, srs, pue;
  wire uio, url, uar, cbv;
  wire [7:0] dbo, dbe, rba, cbyte;
  wire [3:0] w;
  integer fail_count = 0, total_checks = 0;
  assign w = {rba == 8'h01, rdy, uio, cbv};
  initial forever #25 clk = ~clk;
  // External link clock, running only while a byte is offered.
  initial begin
    #7;
    forever #200 ext_clk = ext_run ? ~ext_clk : 1'b0;
  end
  fcp_prom_model prom (.config_clock(cco), .en(use_prom && !cco_n), .din(prom_din));
  fcp_top #(.CFG_BYTES(2), .CLEAR_CYCLES(8)) uut (.clk(clk), .reset_n(reset_n),
    .config_clock_in(cco_n ? ext_clk : cco), .config_clock_out(cco), .config_clock_oe_n(cco_n),
    .serial_data_in(use_prom ? prom_din : bus[0]), .data_bus_in(bus), .data_bus_out(dbo),
    .data_bus_oe_n(dbe), .mode_select_bit0(md[0]), .mode_select_bit1(md[1]),
    .mode_select_bit2(md[2]), .osc_speed_select(osc), .chip_select_low(csl),
    .chip_select_high(csh), .write_strobe_n(wr), .read_strobe_n(rd),
    .program_restart_n(prog), .gen_reset_n(grst), .done_in(doe & ~hold), .done_out(dvo),
    .done_oe_n(doe), .init_in(ioe), .init_out(iev), .init_oe_n(ioe),
    .readback_request_n(rbr), .readback_enable(rben), .tristate_after_cfg(1'b0),
    .gen_reset_is_async(gra), .scan_select(ssel), .scan_tdo(stdo), .readback_byte(8'ha5),
    .readback_addr(rba), .readback_data(rbd), .ready_busy(rdy), .mem_read_strobe(drs),
    .daisy_data_out(dout), .high_while_configuring(hwc), .low_while_configuring(lwc),
    .global_tristate(gts), .scan_reset(srs), .config_pullup_en(pue), .user_io_en(uio),
    .user_reset_level(url), .user_async_reset(uar), .cfg_byte(cbyte), .cfg_byte_valid(cbv));
  task summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Waits a bounded time for one watched condition after at least one edge.
  task waitw(input integer k);
    integer i;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (i < 4000 && w[k] !== 1'b1);
    if (i >= 4000) begin
      fail_count++;
      summarize();
    end
  endtask
  // Counts system clocks between two rises of the driven config clock.
  task per(input integer exp);
    integer n;
    n = 0;
    while (cco !== 1'b0 && n < 999) begin @(posedge clk); #1; n++; end
    while (cco !== 1'b1 && n < 999) begin @(posedge clk); #1; n++; end
    if (n >= 999) begin
      fail_count++;
      summarize();
    end
    n = 0;
    while (cco !== 1'b0 && n < 999) begin @(posedge clk); #1; n++; end
    while (cco !== 1'b1 && n < 999) begin @(posedge clk); #1; n++; end
    if (n >= 999) begin
      fail_count++;
      summarize();
    end
    chk("clock period", n[7:0], exp[7:0]);
  endtask
  // Offers one byte; a slave byte also gets one link clock period.
  task put(input logic [7:0] b, input logic rdl, input logic link);
    @(posedge clk);
    bus <= b;
    csl <= 0;
    csh <= 1;
    rd <= ~rdl;
    wr <= 0;
    ext_run <= link;
    waitw(0);
    chk("loaded byte", cbyte, b);
    if (rdl) chk("bus enable on write", dbe, 8'hff);
    @(posedge clk);
    wr <= 1;
    rd <= 1;
    ext_run <= 0;
    cyc(12);
  endtask
  initial begin
    cyc(16);
    reset_n <= 1;
    per(16);
    waitw(0);
    chk("serial byte 0", cbyte, 8'h3c);
    chk("serial ready", {7'h0, rdy}, 8'h00);
    chk("clock drive", {7'h0, cco_n}, 8'h00);
    chk("daisy out", {7'h0, dout}, 8'h00);
    waitw(0);
    chk("serial byte 1", cbyte, 8'hc5);
    cyc(40);
    chk("held start-up", {6'h0, uio, doe}, 8'h01);
    hold <= 0;
    waitw(1);
    chk("after start-up", {6'h0, lwc, pue}, 8'h02);
    chk("open drain lows", {6'h0, dvo, iev}, 8'h00);
    rbr <= 0;
    cyc(40);
    chk("readback off", rba, 8'h00);
    rbr <= 1;
    rben <= 1;
    cyc(4);
    rbr <= 0;
    waitw(3);
    chk("readback frame", rba, 8'h01);
    repeat (8) begin
      rbits = {rbits[6:0], rbd};
      @(posedge clk);
      #1;
    end
    chk("readback bits", rbits, 8'ha5);
    rbr <= 1;
    cyc(200);
    ssel <= 1;
    stdo <= 1;
    cyc(4);
    chk("scan out high", {7'h0, rbd}, 8'h01);
    stdo <= 0;
    cyc(4);
    chk("scan out low", {7'h0, rbd}, 8'h00);
    gra <= 1;
    grst <= 0;
    cyc(5);
    chk("user reset", {6'h0, uar, url}, 8'h02);
    grst <= 1;
    md <= 3'h4;
    osc <= 0;
    use_prom <= 0;
    prog <= 0;
    cyc(6);
    chk("program restart", {5'h0, srs, ioe, hwc}, 8'h05);
    prog <= 1;
    per(2);
    grst <= 0;
    cyc(5);
    chk("reset restart", {7'h0, ioe}, 8'h00);
    grst <= 1;
    per(2);
    chk("periph clock drive", {7'h0, cco_n}, 8'h00);
    put(8'h5a, 0, 0);
    rd <= 0;
    cyc(4);
    chk("status read", {dbe[7:6], 5'h0, dbo[7]}, 8'h41);
    chk("periph ready", {7'h0, rdy}, 8'h01);
    rd <= 1;
    put(8'h96, 1, 0);
    md <= 3'h3;
    prog <= 0;
    rbr <= 0;
    cyc(6);
    chk("config tristate", {7'h0, gts}, 8'h01);
    prog <= 1;
    rbr <= 1;
    cyc(24);
    chk("slave clock input", {7'h0, cco_n}, 8'h01);
    put(8'he1, 0, 1);
    put(8'h1e, 0, 1);
    waitw(1);
    bus <= 8'h3b;
    md <= 3'h2;
    prog <= 0;
    cyc(6);
    prog <= 1;
    waitw(0);
    chk("parallel byte", cbyte, 8'h3b);
    chk("read strobe", {6'h0, drs, cco}, 8'h02);
    waitw(1);
    summarize();
  end
endmodule
